// ### rtl/tmd_decoder.sv
// Top decode of single-word moves, prefix handling and internal register modules
//
// Operation
// - Each instruction is one 16-bit word: format bit, destination, source.
// - Format bit zero makes the source field an 8-bit immediate.
// - Format bit one reads the operand from the named source register.
// - Source low nibble picks module, high nibble picks register index.
// - Seven-bit destination: low nibble module, upper three bits subindex.
// - Any of sixteen registers of a module is a source in one instruction.
// - Upper 24 destinations need prefix-supplied address bits.
// - Upper destination writes cost one extra prefix cycle.
// - Read-only registers sit at locations 8 to 15 and are never written.
// - Moves to or from special locations trigger arithmetic, logic or branch.
// - Decode and execution of a move complete within one clock.
// - Any register moves anywhere, and combines with the accumulator.
// - Two independent 16-bit data pointers plus a frame pointer.
// - Pointers step after reads and before writes, up or down.
// - Frame address is base plus index; stepping changes only the index.
// - Code pointer reads program memory as data, stepping after each read.
// - Prefix clears one cycle after being written.
// - Registers 16 to 31 need a prefix for both read and write.
// - Void destination stores nothing but source side effects still happen.
`timescale 1ns/1ps
module tmd_decoder (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Instruction from the fetch unit
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    // Branch request to the fetch unit
    output logic jump_r,
    output logic [15:0] jump_addr_r,
    // Source read from external register modules
    output logic ext_src_rd,
    output logic [3:0] ext_src_mod,
    output logic [4:0] ext_src_idx,
    input wire logic [15:0] ext_src_data,
    input wire logic ext_src_hit,
    // Destination write to external register modules
    output logic ext_wr_r,
    output logic [3:0] ext_wr_mod_r,
    output logic [4:0] ext_wr_idx_r,
    output logic [15:0] ext_wr_data_r,
    // Data memory
    output logic [15:0] dmem_raddr,
    output logic dmem_rd,
    input wire logic [15:0] dmem_rdata,
    output logic [15:0] dmem_waddr,
    output logic dmem_wr,
    output logic [15:0] dmem_wdata,
    // Program memory read as data
    output logic [15:0] cmem_addr,
    output logic cmem_rd,
    input wire logic [15:0] cmem_rdata,
    // Status
    output logic pfx_active
);
    // Destination extension register
    logic [7:0] pfx_data_r, pfx_data_nxt;
    logic [2:0] pfx_idx_r, pfx_idx_nxt;
    logic ext_wr_nxt;
    logic [3:0] ext_wr_mod_nxt;
    logic [4:0] ext_wr_idx_nxt;
    logic [15:0] ext_wr_data_nxt;
    logic jump_nxt;
    logic [15:0] jump_addr_nxt;

    // Decoded fields
    logic fmt;
    logic [7:0] src_field;
    logic [6:0] dst_field;
    logic [3:0] src_mod, dst_mod;
    logic [4:0] src_idx, dst_idx;
    logic rd_go;
    logic [15:0] src_val, operand, void_src;
    logic alu_rd_hit, ptr_rd_hit;
    logic [15:0] alu_rd_data, ptr_rd_data;
    logic alu_wr, ptr_wr, pfx_wr, br_wr, dst_ext;
    logic alu_src, ptr_src;

    // Split the word into its three fields
    always_comb begin
        fmt = instr_word[tmd_pkg::FMT_BIT];
        src_field = instr_word[tmd_pkg::SRC_MSB:0];
        dst_field = instr_word[tmd_pkg::DST_MSB:tmd_pkg::DST_LSB];
        src_mod = src_field[3:0];
        src_idx = {pfx_idx_r[2], src_field[7:4]};
        dst_mod = dst_field[3:0];
        dst_idx = {pfx_idx_r[1:0], dst_field[6:4]};
    end

    // Source selection settles within the cycle
    always_comb begin
        rd_go = instr_valid && fmt;
        alu_src = src_mod == tmd_pkg::MOD_ALU;
        ptr_src = src_mod == tmd_pkg::MOD_PTR;
        ext_src_rd = rd_go && !alu_src && !ptr_src && src_mod != tmd_pkg::MOD_PFX;
        ext_src_mod = src_mod;
        ext_src_idx = src_idx;
        // An empty source slot yields the prefix byte over zero
        void_src = {pfx_data_r, 8'h00};
        if (alu_src) begin
            src_val = alu_rd_hit ? alu_rd_data : void_src;
        end else if (ptr_src) begin
            src_val = ptr_rd_hit ? ptr_rd_data : void_src;
        end else if (src_mod == tmd_pkg::MOD_PFX) begin
            src_val = {8'h00, pfx_data_r};
        end else begin
            src_val = ext_src_hit ? ext_src_data : void_src;
        end
        // Immediate takes the prefix byte as high half
        operand = fmt ? src_val : {pfx_data_r, src_field};
    end

    // Destination routing
    always_comb begin
        pfx_wr = instr_valid && dst_mod == tmd_pkg::MOD_PFX;
        alu_wr = instr_valid && dst_mod == tmd_pkg::MOD_ALU;
        ptr_wr = instr_valid && dst_mod == tmd_pkg::MOD_PTR;
        br_wr = instr_valid && dst_mod == tmd_pkg::MOD_BR;
        dst_ext = !(dst_mod == tmd_pkg::MOD_PFX || dst_mod == tmd_pkg::MOD_ALU
                    || dst_mod == tmd_pkg::MOD_PTR || dst_mod == tmd_pkg::MOD_BR);
    end

    // Prefix lives one cycle after its write
    always_comb begin
        pfx_data_nxt = tmd_pkg::PFX_RST;
        pfx_idx_nxt = tmd_pkg::PFX_IDX_RST;
        if (pfx_wr) begin
            pfx_data_nxt = operand[7:0];
            pfx_idx_nxt = dst_field[6:4];
        end
        pfx_active = (pfx_data_r != 8'h00) || (pfx_idx_r != 3'h0);
    end

    // Prefix register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pfx_data_r <= tmd_pkg::PFX_RST;
            pfx_idx_r <= tmd_pkg::PFX_IDX_RST;
        end else begin
            pfx_data_r <= pfx_data_nxt;
            pfx_idx_r <= pfx_idx_nxt;
        end
    end

    // External write and branch requests, sent from flops
    always_comb begin
        ext_wr_nxt = instr_valid && dst_ext;
        ext_wr_mod_nxt = dst_mod;
        ext_wr_idx_nxt = dst_idx;
        ext_wr_data_nxt = operand;
        jump_nxt = br_wr && dst_idx == tmd_pkg::B_JUMP;
        jump_addr_nxt = operand;
        // Hold data when idle to keep the write bus quiet
        if (!ext_wr_nxt) begin
            ext_wr_mod_nxt = ext_wr_mod_r;
            ext_wr_idx_nxt = ext_wr_idx_r;
            ext_wr_data_nxt = ext_wr_data_r;
        end
        if (!jump_nxt) begin
            jump_addr_nxt = jump_addr_r;
        end
    end

    // Output registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ext_wr_r <= 1'b0;
            ext_wr_mod_r <= 4'h0;
            ext_wr_idx_r <= 5'h00;
            ext_wr_data_r <= 16'h0000;
            jump_r <= 1'b0;
            jump_addr_r <= 16'h0000;
        end else begin
            ext_wr_r <= ext_wr_nxt;
            ext_wr_mod_r <= ext_wr_mod_nxt;
            ext_wr_idx_r <= ext_wr_idx_nxt;
            ext_wr_data_r <= ext_wr_data_nxt;
            jump_r <= jump_nxt;
            jump_addr_r <= jump_addr_nxt;
        end
    end

    // Accumulator module
    tmd_alu u_alu (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .wr_en(alu_wr),
        .wr_idx(dst_idx),
        .wr_data(operand),
        .rd_idx(src_idx),
        .rd_data(alu_rd_data),
        .rd_hit(alu_rd_hit)
    );

    // Pointer module; source steps whatever the destination, unless the move also writes the same pointer
    tmd_pointer_unit u_ptr (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .rd_en(rd_go && ptr_src),
        .rd_idx(src_idx),
        .wr_en(ptr_wr),
        .wr_idx(dst_idx),
        .wr_data(operand),
        .rd_data(ptr_rd_data),
        .rd_hit(ptr_rd_hit),
        .dmem_raddr(dmem_raddr),
        .dmem_rd(dmem_rd),
        .dmem_rdata(dmem_rdata),
        .dmem_waddr(dmem_waddr),
        .dmem_wr(dmem_wr),
        .dmem_wdata(dmem_wdata),
        .cmem_addr(cmem_addr),
        .cmem_rd(cmem_rd),
        .cmem_rdata(cmem_rdata)
    );

    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence pfx_load_s;
        pfx_wr && !fmt;
    endsequence
    sequence upper_move_s;
        instr_valid && !pfx_wr && dst_ext;
    endsequence

    imm_operand_a: assert property (
        instr_valid && !fmt |-> operand == {pfx_data_r, instr_word[7:0]})
        else $error("bad immediate");
    reg_source_a: assert property (
        rd_go && ext_src_rd && ext_src_hit |-> operand == ext_src_data)
        else $error("bad reg operand");
    src_fields_a: assert property (
        rd_go |-> ext_src_mod == instr_word[3:0] && ext_src_idx[3:0] == instr_word[7:4])
        else $error("bad src split");
    dst_fields_a: assert property (
        upper_move_s |=> ext_wr_r && ext_wr_mod_r == $past(instr_word[11:8])
        && ext_wr_idx_r[2:0] == $past(instr_word[14:12]))
        else $error("bad dst split");
    pfx_upper_a: assert property (
        pfx_load_s ##1 upper_move_s |=> ext_wr_idx_r[4:3] == $past(pfx_idx_r[1:0])
        && ($past(fmt) || ext_wr_data_r[15:8] == $past(pfx_data_r)))
        else $error("prefix not applied");
    upper_cost_a: assert property (
        ext_wr_r && ext_wr_idx_r[4:3] != 2'b00 |-> $past(pfx_wr, 2))
        else $error("upper write unprefixed");
    pfx_expire_a: assert property (
        pfx_active && !pfx_wr |=> !pfx_active)
        else $error("prefix lingered");
    src_upper_a: assert property (
        rd_go && ext_src_idx[4] |-> $past(pfx_wr))
        else $error("upper read unprefixed");
    jump_move_a: assert property (
        br_wr && dst_idx == tmd_pkg::B_JUMP |=> jump_r && jump_addr_r == $past(operand))
        else $error("jump missed");
    one_cycle_a: assert property (
        instr_valid && !fmt && dst_ext |=> ext_wr_r ##1 !ext_wr_r || $past(instr_valid))
        else $error("move too slow");
    pfx_reset_a: assert property (disable iff (1'b0) !rst_n |=> !pfx_active)
        else $error("prefix set after reset");
endmodule

// ### common/tmd_pkg.sv
// Constants shared by the transport move decoder and its register modules
package tmd_pkg;
    // Instruction word layout
    localparam int INSTR_W = 16;
    localparam int FMT_BIT = 15;
    localparam int DST_LSB = 8;
    localparam int DST_MSB = 14;
    localparam int SRC_MSB = 7;
    // Module specifiers decoded inside the core
    localparam logic [3:0] MOD_ALU = 4'hA;
    localparam logic [3:0] MOD_PFX = 4'hB;
    localparam logic [3:0] MOD_BR = 4'hC;
    localparam logic [3:0] MOD_PTR = 4'hF;
    // Pointer module indices; at 0 to 5, 8 and 9 an even index steps up, an odd one steps down
    localparam logic [4:0] P_DP0_INC = 5'h00;
    localparam logic [4:0] P_DP0_DEC = 5'h01;
    localparam logic [4:0] P_DP1_INC = 5'h02;
    localparam logic [4:0] P_DP1_DEC = 5'h03;
    localparam logic [4:0] P_FP_INC = 5'h04;
    localparam logic [4:0] P_FP_DEC = 5'h05;
    localparam logic [4:0] P_CP_INC = 5'h08;
    localparam logic [4:0] P_CP_DEC = 5'h09;
    localparam logic [4:0] P_DP0 = 5'h10;
    localparam logic [4:0] P_DP1 = 5'h11;
    localparam logic [4:0] P_BP = 5'h12;
    localparam logic [4:0] P_FRAME_INDEX = 5'h13;
    localparam logic [4:0] P_CP = 5'h14;
    // Accumulator module indices
    localparam logic [4:0] A_ACC = 5'h00;
    localparam logic [4:0] A_ADD = 5'h01;
    localparam logic [4:0] A_SUB = 5'h02;
    localparam logic [4:0] A_AND = 5'h03;
    localparam logic [4:0] A_OR = 5'h04;
    localparam logic [4:0] A_XOR = 5'h05;
    localparam logic [4:0] A_FLAGS = 5'h08;
    // Branch module index
    localparam logic [4:0] B_JUMP = 5'h00;
    // Reset values
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic [7:0] FRAME_INDEX_RST = 8'h00;
    localparam logic [15:0] ACC_RST = 16'h0000;
    localparam logic [7:0] PFX_RST = 8'h00;
    localparam logic [2:0] PFX_IDX_RST = 3'h0;
endpackage

// ### rtl/tmd_alu.sv
// Accumulator module: moves into its locations trigger arithmetic and logic
`timescale 1ns/1ps
module tmd_alu (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Write side
    input wire logic wr_en,
    input wire logic [4:0] wr_idx,
    input wire logic [15:0] wr_data,
    // Read side
    input wire logic [4:0] rd_idx,
    output logic [15:0] rd_data,
    output logic rd_hit
);
    logic [15:0] acc_r, acc_nxt;
    logic carry_r, carry_nxt;
    logic [16:0] sum;
    logic [16:0] diff;

    // Operation selected by the destination location
    always_comb begin
        sum = {1'b0, acc_r} + {1'b0, wr_data};
        diff = {1'b0, acc_r} - {1'b0, wr_data};
        acc_nxt = acc_r;
        carry_nxt = carry_r;
        if (wr_en) begin
            case (wr_idx)
                tmd_pkg::A_ACC: acc_nxt = wr_data;
                tmd_pkg::A_ADD: begin
                    acc_nxt = sum[15:0];
                    carry_nxt = sum[16];
                end
                tmd_pkg::A_SUB: begin
                    acc_nxt = diff[15:0];
                    carry_nxt = diff[16];
                end
                tmd_pkg::A_AND: acc_nxt = acc_r & wr_data;
                tmd_pkg::A_OR: acc_nxt = acc_r | wr_data;
                tmd_pkg::A_XOR: acc_nxt = acc_r ^ wr_data;
                default: ; // Undefined location stores nothing
            endcase
        end
        rd_hit = 1'b1;
        case (rd_idx)
            tmd_pkg::A_ACC: rd_data = acc_r;
            tmd_pkg::A_FLAGS: rd_data = {14'h0000, carry_r, acc_r == 16'h0000};
            default: begin
                rd_data = 16'h0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // State registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            acc_r <= tmd_pkg::ACC_RST;
            carry_r <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            carry_r <= carry_nxt;
        end
    end

    add_acc_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_en && wr_idx == tmd_pkg::A_ADD |=> acc_r == 16'($past(acc_r) + $past(wr_data)))
        else $error("add wrong");
endmodule

// ### rtl/tmd_pointer_unit.sv
// Data, frame and code pointers with automatic stepping on memory access
`timescale 1ns/1ps
module tmd_pointer_unit (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register access from the decoder
    input wire logic rd_en,
    input wire logic [4:0] rd_idx,
    input wire logic wr_en,
    input wire logic [4:0] wr_idx,
    input wire logic [15:0] wr_data,
    output logic [15:0] rd_data,
    output logic rd_hit,
    // Data memory, async read port and clocked write port
    output logic [15:0] dmem_raddr,
    output logic dmem_rd,
    input wire logic [15:0] dmem_rdata,
    output logic [15:0] dmem_waddr,
    output logic dmem_wr,
    output logic [15:0] dmem_wdata,
    // Program memory read as data
    output logic [15:0] cmem_addr,
    output logic cmem_rd,
    input wire logic [15:0] cmem_rdata
);
    logic [15:0] dp0_r, dp0_nxt, dp1_r, dp1_nxt, bp_r, bp_nxt, cp_r, cp_nxt;
    logic [7:0] frame_index_r, frame_index_nxt, frame_index_wr;

    function automatic logic [15:0] step(input logic [15:0] v, input logic dec);
        step = dec ? v - 16'h0001 : v + 16'h0001;
    endfunction

    // Reads step after the access, writes step before it
    always_comb begin
        dp0_nxt = dp0_r;
        dp1_nxt = dp1_r;
        bp_nxt = bp_r;
        cp_nxt = cp_r;
        frame_index_nxt = frame_index_r;
        frame_index_wr = wr_idx[0] ? frame_index_r - 8'h01 : frame_index_r + 8'h01;
        rd_data = 16'h0000;
        rd_hit = rd_en;
        dmem_rd = 1'b0;
        dmem_raddr = dp0_r;
        dmem_wr = 1'b0;
        dmem_waddr = dp0_r;
        dmem_wdata = wr_data;
        cmem_addr = cp_r;
        cmem_rd = 1'b0;
        // Source side effects happen even for a void destination
        if (rd_en) begin
            case (rd_idx)
                tmd_pkg::P_DP0_INC, tmd_pkg::P_DP0_DEC: begin
                    dmem_rd = 1'b1;
                    rd_data = dmem_rdata;
                    dp0_nxt = step(dp0_r, rd_idx[0]);
                end
                tmd_pkg::P_DP1_INC, tmd_pkg::P_DP1_DEC: begin
                    dmem_rd = 1'b1;
                    dmem_raddr = dp1_r;
                    rd_data = dmem_rdata;
                    dp1_nxt = step(dp1_r, rd_idx[0]);
                end
                tmd_pkg::P_FP_INC, tmd_pkg::P_FP_DEC: begin
                    dmem_rd = 1'b1;
                    dmem_raddr = bp_r + {8'h00, frame_index_r};
                    rd_data = dmem_rdata;
                    frame_index_nxt = rd_idx[0] ? frame_index_r - 8'h01 : frame_index_r + 8'h01;
                end
                tmd_pkg::P_CP_INC, tmd_pkg::P_CP_DEC: begin
                    cmem_rd = 1'b1;
                    rd_data = cmem_rdata;
                    cp_nxt = step(cp_r, rd_idx[0]);
                end
                tmd_pkg::P_DP0: rd_data = dp0_r;
                tmd_pkg::P_DP1: rd_data = dp1_r;
                tmd_pkg::P_BP: rd_data = bp_r;
                tmd_pkg::P_FRAME_INDEX: rd_data = {8'h00, frame_index_r};
                tmd_pkg::P_CP: rd_data = cp_r;
                default: rd_hit = 1'b0;
            endcase
        end
        // A write to the same pointer in one move wins over the read step
        if (wr_en) begin
            case (wr_idx)
                tmd_pkg::P_DP0_INC, tmd_pkg::P_DP0_DEC: begin
                    dp0_nxt = step(dp0_r, wr_idx[0]);
                    dmem_wr = 1'b1;
                    dmem_waddr = step(dp0_r, wr_idx[0]);
                end
                tmd_pkg::P_DP1_INC, tmd_pkg::P_DP1_DEC: begin
                    dp1_nxt = step(dp1_r, wr_idx[0]);
                    dmem_wr = 1'b1;
                    dmem_waddr = step(dp1_r, wr_idx[0]);
                end
                tmd_pkg::P_FP_INC, tmd_pkg::P_FP_DEC: begin
                    frame_index_nxt = frame_index_wr;
                    dmem_wr = 1'b1;
                    dmem_waddr = bp_r + {8'h00, frame_index_wr};
                end
                tmd_pkg::P_DP0: dp0_nxt = wr_data;
                tmd_pkg::P_DP1: dp1_nxt = wr_data;
                tmd_pkg::P_BP: bp_nxt = wr_data;
                tmd_pkg::P_FRAME_INDEX: frame_index_nxt = wr_data[7:0];
                tmd_pkg::P_CP: cp_nxt = wr_data;
                default: ; // Void and read-only slots store nothing
            endcase
        end
    end

    // Pointer registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dp0_r <= tmd_pkg::PTR_RST;
            dp1_r <= tmd_pkg::PTR_RST;
            bp_r <= tmd_pkg::PTR_RST;
            cp_r <= tmd_pkg::PTR_RST;
            frame_index_r <= tmd_pkg::FRAME_INDEX_RST;
        end else begin
            dp0_r <= dp0_nxt;
            dp1_r <= dp1_nxt;
            bp_r <= bp_nxt;
            cp_r <= cp_nxt;
            frame_index_r <= frame_index_nxt;
        end
    end

    dp_post_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rd_en && rd_idx == tmd_pkg::P_DP0_INC && !wr_en
        |=> dp0_r == $past(dp0_r) + 16'h0001 && $stable(dp1_r))
        else $error("dp step wrong");
    fp_base_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_en && wr_idx == tmd_pkg::P_FP_DEC
        |-> dmem_waddr == bp_r + {8'h00, frame_index_r - 8'h01} ##1 $stable(bp_r))
        else $error("base moved");
    cp_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rd_en && rd_idx == tmd_pkg::P_CP_DEC && !(wr_en && wr_idx == tmd_pkg::P_CP)
        |-> cmem_rd && cmem_addr == cp_r ##1 cp_r == $past(cp_r) - 16'h0001)
        else $error("cp step wrong");
endmodule

// ### verif/tmd_far_model.sv
// Far side: external registers, data memory, code memory
`timescale 1ns/1ps
module tmd_far_model (
    // Clock
    input wire logic sys_clk,
    // External register modules
    input wire logic ext_src_rd,
    input wire logic [3:0] ext_src_mod,
    input wire logic [4:0] ext_src_idx,
    output logic [15:0] ext_src_data,
    output logic ext_src_hit,
    input wire logic ext_wr_r,
    input wire logic [3:0] ext_wr_mod_r,
    input wire logic [4:0] ext_wr_idx_r,
    input wire logic [15:0] ext_wr_data_r,
    // Data memory
    input wire logic [15:0] dmem_raddr,
    input wire logic dmem_rd,
    output logic [15:0] dmem_rdata,
    input wire logic [15:0] dmem_waddr,
    input wire logic dmem_wr,
    input wire logic [15:0] dmem_wdata,
    // Code memory
    input wire logic [15:0] cmem_addr,
    input wire logic cmem_rd,
    output logic [15:0] cmem_rdata
);
    logic [15:0] regs [0:511];
    logic [15:0] dmem [0:255];
    logic [15:0] noise_r = 16'h5A5A;
    // Address-derived pattern the bench can predict
    initial begin
        for (int i = 0; i < 256; i++) dmem[i] = {8'(i), ~8'(i)};
    end
    // Idle lines churn so stale data never passes
    always @(posedge sys_clk) begin
        noise_r <= {noise_r[14:0], noise_r[15] ^ noise_r[13]};
        if (ext_wr_r) regs[{ext_wr_mod_r, ext_wr_idx_r}] <= ext_wr_data_r;
        if (dmem_wr) dmem[dmem_waddr[7:0]] <= dmem_wdata;
    end
    // Only modules 0 to 5 exist outside the core
    assign ext_src_hit = ext_src_mod < 4'h6;
    assign ext_src_data = ext_src_rd ? regs[{ext_src_mod, ext_src_idx}] : noise_r;
    assign dmem_rdata = dmem_rd ? dmem[dmem_raddr[7:0]] : ~noise_r;
    assign cmem_rdata = cmem_rd ? (cmem_addr ^ 16'h3C96) : (noise_r ^ 16'h0F0F);
endmodule

// ### verif/tb_top.sv
// Self-checking bench for the transport move decoder
`timescale 1ns/1ps
module tb_top;
    logic sys_clk, rst_n, instr_valid, jump_r, ext_src_rd, ext_src_hit, ext_wr_r;
    logic dmem_rd, dmem_wr, cmem_rd, pfx_active;
    logic [15:0] instr_word, jump_addr_r, ext_src_data, ext_wr_data_r, dmem_raddr;
    logic [15:0] dmem_rdata, dmem_waddr, dmem_wdata, cmem_addr, cmem_rdata;
    logic [3:0] ext_src_mod, ext_wr_mod_r;
    logic [4:0] ext_src_idx, ext_wr_idx_r;
    logic [4:0] ops [5] = '{tmd_pkg::A_ADD, tmd_pkg::A_SUB, tmd_pkg::A_AND,
        tmd_pkg::A_OR, tmd_pkg::A_XOR};
    logic [31:0] seed = 32'h8DA6;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    tmd_decoder dut (.sys_clk, .rst_n, .instr_word, .instr_valid, .jump_r, .jump_addr_r,
        .ext_src_rd, .ext_src_mod, .ext_src_idx, .ext_src_data, .ext_src_hit, .ext_wr_r,
        .ext_wr_mod_r, .ext_wr_idx_r, .ext_wr_data_r, .dmem_raddr, .dmem_rd, .dmem_rdata,
        .dmem_waddr, .dmem_wr, .dmem_wdata, .cmem_addr, .cmem_rd, .cmem_rdata, .pfx_active);
    tmd_far_model far (.sys_clk, .ext_src_rd, .ext_src_mod, .ext_src_idx, .ext_src_data,
        .ext_src_hit, .ext_wr_r, .ext_wr_mod_r, .ext_wr_idx_r, .ext_wr_data_r, .dmem_raddr,
        .dmem_rd, .dmem_rdata, .dmem_waddr, .dmem_wr, .dmem_wdata, .cmem_addr, .cmem_rd,
        .cmem_rdata);
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // Hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end
    function automatic logic [15:0] rnd();
        seed = {1'b0, seed[31:1]} ^ (seed[0] ? 32'h8020_0003 : 32'h0000_0000);
        return seed[15:0];
    endfunction
    function automatic logic [15:0] alu_exp(logic [4:0] op, logic [15:0] a, logic [15:0] b);
        case (op)
            tmd_pkg::A_ADD: return a + b;
            tmd_pkg::A_SUB: return a - b;
            tmd_pkg::A_AND: return a & b;
            tmd_pkg::A_OR: return a | b;
            default: return a ^ b;
        endcase
    endfunction
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One move per call, held a full cycle
    task automatic issue(input logic [15:0] w);
        @(posedge sys_clk);
        instr_word <= w;
        instr_valid <= 1'b1;
        #1;
    endtask
    task automatic idle();
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        instr_word <= rnd();
        #1;
    endtask
    // Full write: prefix gives high byte, index bits 4:3
    task automatic wr16(input logic [3:0] m, input logic [4:0] i, input logic [15:0] d);
        issue({2'b00, i[4:3], 4'hB, d[15:8]});
        issue({1'b0, i[2:0], m, d[7:0]});
        idle();
    endtask
    task automatic exp_wr(input logic [3:0] m, input logic [4:0] i, input logic [15:0] d);
        chk("ext_wr", {7'h01, m, i}, {6'h00, ext_wr_r, ext_wr_mod_r, ext_wr_idx_r});
        chk("ext_wr_data_r", d, ext_wr_data_r);
    endtask
    task automatic tally_and_finish();
        $display("Checks run %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        logic [15:0] a, b, v, dp;
        logic [3:0] m;
        rst_n = 1'b0;
        instr_valid = 1'b0;
        instr_word = 16'h0000;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        chk("pfx_active", 16'h0000, 16'(pfx_active));
        // Immediate moves, no prefix
        repeat (8) begin
            m = 4'(rnd() % 16'h0006);
            v = rnd();
            issue({1'b0, v[10:8], m, v[7:0]});
            idle();
            exp_wr(m, {2'b00, v[10:8]}, {8'h00, v[7:0]});
        end
        // Prefixed writes, read back as a source
        for (int n = 0; n < 4; n++) begin
            v = rnd() | 16'h8000;
            m = 4'(n);
            issue({2'b00, n[1:0], 4'hB, v[15:8]});
            issue({1'b0, v[2:0], m, v[7:0]});
            chk("pfx_active", 16'h0001, 16'(pfx_active));
            idle();
            chk("pfx_active", 16'h0000, 16'(pfx_active));
            exp_wr(m, {n[1:0], v[2:0]}, v);
            if (n >= 2) issue({4'h4, 4'hB, 8'h00});
            issue({1'b1, 3'd7, 4'h5, n[0], v[2:0], m});
            chk("ext_src", {7'h01, m, n[1:0], v[2:0]}, {6'h00, ext_src_rd, ext_src_mod, ext_src_idx});
            idle();
            exp_wr(4'h5, 5'd7, v);
        end
        // Every accumulator operation
        foreach (ops[k]) begin
            a = rnd();
            b = rnd();
            wr16(tmd_pkg::MOD_ALU, tmd_pkg::A_ACC, a);
            wr16(tmd_pkg::MOD_ALU, ops[k], b);
            issue(16'h840A);
            idle();
            exp_wr(4'h4, 5'd0, alu_exp(ops[k], a, b));
        end
        // Data pointers step after reads, before writes
        a = 16'h0050;
        b = 16'h0090;
        wr16(4'hF, tmd_pkg::P_DP0, a);
        wr16(4'hF, tmd_pkg::P_DP1, b);
        for (int k = 0; k < 2; k++) begin
            dp = k ? b : a;
            v = rnd();
            issue({1'b1, 3'd0, 4'h3, 2'b00, k[0], 1'b0, 4'hF});
            chk("dmem_raddr", dp, dmem_raddr & {16{dmem_rd}});
            idle();
            exp_wr(4'h3, 5'd0, {dp[7:0], ~dp[7:0]});
            issue({2'b00, k[0], 1'b0, 4'hF, v[7:0]});
            chk("dmem_waddr", dp + 16'h0002, dmem_waddr);
            chk("dmem_wdata", {8'h00, v[7:0]}, dmem_wdata);
            issue({1'b1, 3'd0, 4'h3, 2'b00, k[0], 1'b1, 4'hF});
            chk("dmem_raddr", dp + 16'h0002, dmem_raddr);
            idle();
            exp_wr(4'h3, 5'd0, {8'h00, v[7:0]});
        end
        // Void destination still steps the source
        issue({4'h1, 4'hB, 8'h00});
        issue({1'b1, 3'd0, 4'hF, 8'h1F});
        idle();
        chk("ext_wr_r", 16'h0000, 16'(ext_wr_r));
        issue({1'b1, 3'd0, 4'h3, 8'h0F});
        chk("dmem_raddr", a, dmem_raddr);
        idle();
        // Frame pointer: only the index steps
        wr16(4'hF, tmd_pkg::P_BP, 16'h0020);
        wr16(4'hF, tmd_pkg::P_FRAME_INDEX, 16'h0005);
        for (int k = 0; k < 2; k++) begin
            issue({1'b1, 3'd0, 4'h3, 8'h4F});
            chk("dmem_raddr", 16'h0025 + 16'(k), dmem_raddr);
        end
        issue({1'b0, 3'd5, 4'hF, 8'h77});
        chk("dmem_waddr", 16'h0026, dmem_waddr & {16{dmem_wr}});
        issue({4'h4, 4'hB, 8'h00});
        issue({1'b1, 3'd0, 4'h3, 8'h2F});
        idle();
        exp_wr(4'h3, 5'd0, 16'h0020);
        // Code pointer reads program memory as data
        wr16(4'hF, tmd_pkg::P_CP, 16'h1234);
        for (int k = 0; k < 2; k++) begin
            issue({1'b1, 3'd0, 4'h3, 3'b100, k[0], 4'hF});
            chk("cmem_addr", 16'h1234 + 16'(k), cmem_addr & {16{cmem_rd}});
            idle();
            exp_wr(4'h3, 5'd0, (16'h1234 + 16'(k)) ^ 16'h3C96);
        end
        // Branch as a plain move
        v = rnd();
        wr16(tmd_pkg::MOD_BR, tmd_pkg::B_JUMP, v);
        chk("jump_r", 16'h0001, 16'(jump_r));
        chk("jump_addr_r", v, jump_addr_r);
        idle();
        chk("jump_r", 16'h0000, 16'(jump_r));
        tally_and_finish();
    end
endmodule
